//--- src/eic_top.sv
// Purpose: interrupt controller with regular and enhanced operation
// Assumes: requests are levels held by their sources until serviced
// Notes:   control bits and register images are plain ports
`timescale 1ns/1ns
module eic_top (
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    // request sources
    input  wire logic [7:0]  irq_pin_i,
    input  wire logic [7:0]  sys_level_i,
    input  wire logic [31:0] bridge_level_i,
    // configuration bits
    input  wire logic        enhanced_ctrl_enable_i,
    input  wire logic        low_prio_auto_mask_enable_i,
    input  wire logic        ext_irq_reloc_enable_i,
    input  wire logic        exc_table_reloc_enable_i,
    // register writes
    input  wire logic        mask_wr_i,
    input  wire logic        mask_a_wr_i,
    input  wire logic        mask_b_wr_i,
    input  wire logic        base_wr_i,
    input  wire logic [31:0] wdata_i,
    // core handshake
    input  wire logic        irq_ack_i,
    input  wire logic        isr_done_i,
    output logic             irq_o,
    output logic [31:0]      vector_addr_o,
    output logic [7:0]       vector_code_reg_o,
    // register images
    output logic [15:0]      pending_reg_o,
    output logic [31:0]      pending_reg_a_o,
    output logic [31:0]      pending_reg_b_o,
    output logic [15:0]      level_mask_reg_o,
    output logic [31:0]      level_mask_reg_a_o,
    output logic [31:0]      level_mask_reg_b_o,
    output logic [31:0]      branch_table_base_reg_o,
    output logic [31:0]      auto_mask_status_a_o,
    output logic [31:0]      auto_mask_status_b_o
);
    localparam int NS = eic_pkg::NUM_SRC;

    logic [NS-1:0]  pend_q;
    logic [NS-1:0]  pend_d;
    logic [15:0]    mask_q;
    logic [15:0]    mask_d;
    logic [31:0]    mask_a_q;
    logic [31:0]    mask_a_d;
    logic [15:0]    mask_b_q;
    logic [15:0]    mask_b_d;
    logic [31:0]    base_q;
    logic [31:0]    base_d;
    logic [NS-1:0]  insvc_q;
    logic [NS-1:0]  insvc_d;
    logic [NS-1:0]  auto_q;
    logic [NS-1:0]  auto_d;
    logic           irq_q;
    logic           irq_d;
    logic [7:0]     code_q;
    logic [7:0]     code_d;
    logic [31:0]    vaddr_q;
    logic [31:0]    vaddr_d;
    logic           enh;
    logic           lpm;
    logic           reloc;
    logic [NS-1:0]  en_mask;
    logic [NS-1:0]  eligible;

    eic_sel_if win_if ();
    eic_sel_if svc_if ();

    eic_prio_enc u_win (
        .sel (win_if)
    );

    eic_prio_enc u_svc (
        .sel (svc_if)
    );

    assign enh   = enhanced_ctrl_enable_i;
    assign lpm   = enh && low_prio_auto_mask_enable_i;
    assign reloc = enh && ext_irq_reloc_enable_i && exc_table_reloc_enable_i;

    // source mapping: pins and system levels interleave by priority
    always_comb begin
        pend_d = '0;
        for (int i = 0; i < eic_pkg::NUM_PINS; i++) begin
            pend_d[2*i]   = irq_pin_i[i];
            // regular mode folds bridge levels 0 to 7 onto the eight system levels
            pend_d[2*i+1] = sys_level_i[i] || (!enh && bridge_level_i[i]);
        end
        if (enh) begin
            pend_d[NS-1:eic_pkg::BRIDGE_LSB] = bridge_level_i;
        end
    end

    // mask and base registers
    always_comb begin
        mask_d   = mask_q;
        mask_a_d = mask_a_q;
        mask_b_d = mask_b_q;
        base_d   = base_q;
        if (mask_wr_i) begin
            mask_d = wdata_i[15:0];
        end
        if (mask_a_wr_i) begin
            mask_a_d = wdata_i;
        end
        if (mask_b_wr_i) begin
            mask_b_d = wdata_i[15:0];
        end
        if (base_wr_i) begin
            base_d = wdata_i;
        end
    end

    // effective enable: enhanced pair replaces the single mask
    always_comb begin
        if (enh) begin
            en_mask = {mask_b_q, mask_a_q};
        end else begin
            en_mask = {32'h0000_0000, mask_q};
        end
    end

    assign eligible   = pend_q & en_mask & ~auto_q;
    assign win_if.req = eligible;
    assign svc_if.req = insvc_q;

    // auto mask: every source at or below the best one in service
    generate
        for (genvar b = 0; b < NS; b++) begin : g_auto
            assign auto_d[b] = lpm && svc_if.any
                               && (eic_pkg::IDX_W'(b) >= svc_if.idx);
        end
    endgenerate

    // in-service tracking and vectoring
    always_comb begin
        insvc_d = insvc_q;
        if (!lpm) begin
            insvc_d = '0;
        end else begin
            if (isr_done_i && svc_if.any) begin
                insvc_d[svc_if.idx] = 1'b0;
            end
            if (irq_ack_i && win_if.any) begin
                insvc_d[win_if.idx] = 1'b1;
            end
        end
        irq_d  = win_if.any;
        code_d = {2'b00, win_if.idx};
        if (reloc) begin
            vaddr_d = base_q + (32'(win_if.idx) << eic_pkg::ENTRY_SHIFT);
        end else begin
            vaddr_d = eic_pkg::SHARED_VECTOR;
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            pend_q   <= '0;
            mask_q   <= eic_pkg::MASK_RST;
            mask_a_q <= eic_pkg::MASK_A_RST;
            mask_b_q <= eic_pkg::MASK_B_RST;
            base_q   <= eic_pkg::BASE_RST;
            insvc_q  <= '0;
            auto_q   <= '0;
            irq_q    <= 1'b0;
            code_q   <= eic_pkg::CODE_RST;
            vaddr_q  <= eic_pkg::SHARED_VECTOR;
        end else begin
            pend_q   <= pend_d;
            mask_q   <= mask_d;
            mask_a_q <= mask_a_d;
            mask_b_q <= mask_b_d;
            base_q   <= base_d;
            insvc_q  <= insvc_d;
            auto_q   <= auto_d;
            irq_q    <= irq_d;
            code_q   <= code_d;
            vaddr_q  <= vaddr_d;
        end
    end

    // register images
    always_comb begin
        pending_reg_o   = 16'h0000;
        pending_reg_a_o = 32'h0000_0000;
        pending_reg_b_o = 32'h0000_0000;
        if (enh) begin
            pending_reg_a_o = pend_q[eic_pkg::SPLIT_LSB-1:0];
            pending_reg_b_o = {16'h0000, pend_q[NS-1:eic_pkg::SPLIT_LSB]};
        end else begin
            pending_reg_o = pend_q[15:0];
        end
    end

    assign irq_o                   = irq_q;
    assign vector_addr_o           = vaddr_q;
    assign vector_code_reg_o       = code_q;
    assign level_mask_reg_o        = mask_q;
    assign level_mask_reg_a_o      = mask_a_q;
    assign level_mask_reg_b_o      = {16'h0000, mask_b_q};
    assign branch_table_base_reg_o = base_q;
    assign auto_mask_status_a_o    = auto_q[eic_pkg::SPLIT_LSB-1:0];
    assign auto_mask_status_b_o    = {16'h0000, auto_q[NS-1:eic_pkg::SPLIT_LSB]};
endmodule

//--- inc/eic_pkg.sv
// Purpose: shared constants of the enhanced interrupt controller
// Assumes: one clock domain, plain control ports, no register bus
// Notes:   source index 0 is the highest priority
package eic_pkg;
    // source counts
    localparam int NUM_PINS          = 8;
    localparam int NUM_SYS_LEVELS    = 8;
    localparam int NUM_BRIDGE_LEVELS = 32;
    localparam int NUM_REG_SRC       = NUM_PINS + NUM_SYS_LEVELS;
    localparam int NUM_SRC           = NUM_REG_SRC + NUM_BRIDGE_LEVELS;
    localparam int IDX_W             = 6;
    localparam int CODE_W            = 8;
    // field positions inside the unified source vector
    localparam int BRIDGE_LSB        = NUM_REG_SRC;
    localparam int SPLIT_LSB         = 32;
    // vectoring
    localparam logic [31:0] SHARED_VECTOR = 32'h0000_0500;
    localparam int          ENTRY_SHIFT   = 3;
    // values after reset
    localparam logic [15:0] MASK_RST      = 16'h0000;
    localparam logic [31:0] MASK_A_RST    = 32'h0000_0000;
    localparam logic [15:0] MASK_B_RST    = 16'h0000;
    localparam logic [31:0] BASE_RST      = 32'h0000_0000;
    localparam logic [7:0]  CODE_RST      = 8'h00;
endpackage

//--- inc/eic_sel_if.sv
// Purpose: request vector and winning index between encoder and user
// Assumes: combinational selection
// Notes:   one instance per vector to be searched
`timescale 1ns/1ns
interface eic_sel_if;
    logic [eic_pkg::NUM_SRC-1:0] req;
    logic                        any;
    logic [eic_pkg::IDX_W-1:0]   idx;
    modport enc  (input req, output any, output idx);
    modport user (output req, input any, input idx);
endinterface

//--- src/eic_prio_enc.sv
// Purpose: finds the lowest set index of a request vector
// Assumes: index 0 has the highest priority
// Notes:   purely combinational
`timescale 1ns/1ns
module eic_prio_enc (
    // selection
    eic_sel_if.enc sel
);
    always_comb begin
        sel.any = 1'b0;
        sel.idx = '0;
        for (int i = eic_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (sel.req[i]) begin
                sel.any = 1'b1;
                sel.idx = eic_pkg::IDX_W'(i);
            end
        end
    end
endmodule

//--- testbench/eic_core_model.sv
// Purpose: core model taking interrupts
// Assumes: delay_i at least 5
// Notes:   one routine at a time
`timescale 1ns/1ns
module eic_core_model (
    // clock and reset
    input  wire logic       clock_i,
    input  wire logic       reset_i,
    // core side
    input  wire logic       irq_i,
    input  wire logic [3:0] delay_i,
    output logic            ack_o,
    output logic            done_o
);
    logic [3:0] cnt_q;
    logic       busy_q;
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            {ack_o, done_o, busy_q, cnt_q} <= '0;
        end else begin
            ack_o  <= irq_i && !busy_q;
            done_o <= busy_q && cnt_q == 0;
            busy_q <= busy_q ? cnt_q != 0 : irq_i;
            cnt_q  <= busy_q ? cnt_q - 4'h1 : delay_i;
        end
    end
endmodule

//--- testbench/eic_properties.sv
// Purpose: port assertions of eic_top
// Assumes: one clock, async reset
// Notes:   bound into eic_top
`timescale 1ns/1ns
module eic_properties (
    // clock and reset
    input wire logic        clock_i,
    input wire logic        reset_i,
    // watched inputs
    input wire logic        base_wr_i,
    input wire logic        irq_ack_i,
    input wire logic        isr_done_i,
    input wire logic        enhanced_ctrl_enable_i,
    input wire logic        low_prio_auto_mask_enable_i,
    input wire logic        ext_irq_reloc_enable_i,
    input wire logic        exc_table_reloc_enable_i,
    input wire logic [31:0] bridge_level_i,
    input wire logic [31:0] wdata_i,
    // watched outputs
    input wire logic        irq_o,
    input wire logic [7:0]  vector_code_reg_o,
    input wire logic [31:0] vector_addr_o,
    input wire logic [15:0] pending_reg_o,
    input wire logic [31:0] pending_reg_a_o,
    input wire logic [31:0] pending_reg_b_o,
    input wire logic [31:0] branch_table_base_reg_o,
    input wire logic [31:0] auto_mask_status_b_o
);
    wire en = enhanced_ctrl_enable_i;
    wire lp = low_prio_auto_mask_enable_i;
    wire rel = en && ext_irq_reloc_enable_i && exc_table_reloc_enable_i;
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    a_split_a_zero: assert property (!en |-> pending_reg_a_o == 0)
        else $error("split a set");
    a_split_b_zero: assert property (!en |-> pending_reg_b_o == 0)
        else $error("split b set");
    a_upper_image: assert property (en && $past(en) |-> pending_reg_o == 0 &&
        pending_reg_b_o == {16'h0000, $past(bridge_level_i[31:16])}) else $error("upper");
    a_bridge_levels: assert property (en && $past(en) |->
        pending_reg_a_o[31:16] == $past(bridge_level_i[15:0])) else $error("bridge");
    a_shared_vector: assert property (!ext_irq_reloc_enable_i [*3] |->
        vector_addr_o == 32'h0000_0500) else $error("not shared");
    a_reloc_entry: assert property ($past(rel) && irq_o |-> vector_addr_o ==
        $past(branch_table_base_reg_o) + {vector_code_reg_o, 3'b000}) else $error("entry");
    a_base_write: assert property (base_wr_i |=>
        branch_table_base_reg_o == $past(wdata_i)) else $error("base");
    a_auto_mask: assert property (irq_ack_i && irq_o && en && lp ##1
        (en && lp && !isr_done_i) [*4] |-> auto_mask_status_b_o[15]) else $error("auto");
endmodule
bind eic_top eic_properties u_props (.*);

//--- testbench/tb.sv
// Purpose: self-checking bench of eic_top
// Assumes: core model serves each interrupt
// Notes:   pending images checked every cycle
`timescale 1ns/1ns
module tb;
    logic        clk = 0, rst = 1, en = 0, lp = 0, reloc = 0, xtab = 0, irq, ack, done;
    logic [3:0]  wr = 0, dly = 4'h5;
    logic [7:0]  pin = 0, sys = 0, code;
    logic [15:0] p0, m0;
    logic [31:0] br = 0, wd = 0, rs = 32'hb1e1_f033, base, va, pa, pb, ma, mb, bs, asa, asb;
    logic [47:0] src;
    int          miscompares = 0, total_checks = 0, idx;
    eic_top u_dut (.clock_i(clk), .reset_i(rst), .irq_pin_i(pin), .sys_level_i(sys),
        .bridge_level_i(br), .enhanced_ctrl_enable_i(en), .low_prio_auto_mask_enable_i(lp),
        .ext_irq_reloc_enable_i(reloc), .exc_table_reloc_enable_i(xtab), .mask_wr_i(wr[0]),
        .mask_a_wr_i(wr[1]), .mask_b_wr_i(wr[2]), .base_wr_i(wr[3]), .wdata_i(wd),
        .irq_ack_i(ack), .isr_done_i(done), .irq_o(irq), .vector_addr_o(va),
        .vector_code_reg_o(code), .pending_reg_o(p0), .pending_reg_a_o(pa),
        .pending_reg_b_o(pb), .level_mask_reg_o(m0), .level_mask_reg_a_o(ma),
        .level_mask_reg_b_o(mb), .branch_table_base_reg_o(bs),
        .auto_mask_status_a_o(asa), .auto_mask_status_b_o(asb));
    eic_core_model u_core (.clock_i(clk), .reset_i(rst), .irq_i(irq), .delay_i(dly),
        .ack_o(ack), .done_o(done));
    initial forever #20 clk = ~clk;
    initial begin
        #100_000;
        miscompares++;
        tally_and_finish();
    end
    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    task automatic cmp(input logic [79:0] got, input logic [79:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %h %h", $time, got, exp);
        end
    endtask
    task automatic step();
        logic [15:0] r;
        logic [79:0] e;
        for (int i = 0; i < 8; i++)
            r[2*i +: 2] = {sys[i] | (!en & br[i]), pin[i]};
        e = en ? {16'h0000, br, r, 16'h0000} : {64'h0, r};
        @(posedge clk);
        #1;
        cmp({pb, pa, p0}, e);
    endtask
    task automatic wrt(input int s, input logic [31:0] d);
        wd = d;
        wr = 4'(1 << s);
        step();
        wr = 4'h0;
        step();
        cmp(s == 0 ? m0 : s == 1 ? ma : s == 2 ? mb : bs, s % 2 ? d : {16'h0000, d[15:0]});
    endtask
    task automatic tally_and_finish();
        if (miscompares == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        #1;
        rst = 0;
        cmp({irq, code, va, p0}, {1'b0, 8'h00, 32'h0000_0500, 16'h0000});
        repeat (200) begin
            br = rnd();
            wd = rnd();
            {pin, sys, en} = wd[16:0];
            step();
        end
        {pin, sys, br, en} = '0;
        base = rnd();
        wrt(0, rnd());
        wrt(3, base);
        xtab = 1;
        reloc = 1;
        step();
        en = 1;
        lp = 1;
        wrt(1, '1);
        wrt(2, '1);
        repeat (12) begin
            idx = rnd() % 48;
            reloc = rs[9];
            dly = 4'(5 + rnd() % 8);
            src = 48'h1 << idx;
            for (int i = 0; i < 8; i++)
                {sys[i], pin[i]} = src[2*i +: 2];
            br = src[47:16];
            repeat (2) step();
            cmp({irq, code, va},
                {1'b1, 8'(idx), reloc ? base + 32'(idx * 8) : 32'h0000_0500});
            repeat (3) step();
            cmp({asb, asa}, {16'h0000, 48'hffff_ffff_ffff << idx});
            {pin, sys, br} = '0;
            repeat (14) step();
            cmp({irq, asb, asa}, '0);
        end
        tally_and_finish();
    end
endmodule
